// ### pkg/asb_pkg.sv
// Purpose: Shared constants and types for the converter selection control
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes:   Offsets, field positions, reset values and timing counts
package asb_pkg;

    // Register byte offsets
    localparam logic [7:0] SEL_OFFSET    = 8'h00; // Selection register
    localparam logic [7:0] CTRL_OFFSET   = 8'h04; // Control and status
    localparam logic [7:0] RESULT_OFFSET = 8'h08; // Conversion result
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h0C; // Sticky events
    localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h10; // Event enables
    localparam logic [7:0] IRQ_CLEAR_OFFSET  = 8'h14; // Write one to clear
    localparam logic [7:0] SLEEP_OFFSET  = 8'h18; // Sleep mode command

    // Selection register fields
    localparam int CHAN_LSB = 0;                 // channel_select 4:0
    localparam int CHAN_W   = 5;
    localparam int REF_LSB  = 6;                 // reference_select 7:6
    localparam int REF_W    = 2;
    localparam logic [7:0] SEL_RESET = 8'h00;

    // Control register bit positions
    localparam int CTRL_ENABLE_BIT = 7;          // converter_enable
    localparam int CTRL_START_BIT  = 6;          // start_conversion_bit
    localparam int CTRL_AUTO_BIT   = 5;          // auto_trigger_enable
    localparam int CTRL_FLAG_BIT   = 4;          // conversion_complete_flag
    localparam int CTRL_IE_BIT     = 3;          // Complete interrupt enable
    localparam int CTRL_FREE_BIT   = 0;          // Free-running trigger
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Interrupt status bits
    localparam int IRQ_DONE_BIT  = 0;            // Conversion complete
    localparam int IRQ_START_BIT = 1;            // Conversion started
    localparam int IRQ_W         = 2;

    // Reference source encodings
    localparam logic [1:0] REF_EXT_PIN  = 2'h0;  // external_reference_pin
    localparam logic [1:0] REF_SUPPLY   = 2'h1;  // analog_supply_pin
    localparam logic [1:0] REF_RESERVED = 2'h2;
    localparam logic [1:0] REF_INTERNAL = 2'h3;  // Internal 1.1V reference

    // Sleep mode codes
    localparam logic [2:0] SLEEP_IDLE  = 3'h0;
    localparam logic [2:0] SLEEP_NOISE = 3'h1;   // Noise reduction

    // Conversion timing in converter clock cycles
    localparam int CONV_NORMAL_CYC = 13;         // Normal conversion
    localparam int CONV_FIRST_CYC  = 25;         // First after enabling
    localparam int RESULT_W        = 10;         // Resolution in bits
    localparam logic [9:0] RESULT_MAX = 10'h3FF; // Highest code

    // Converter selection as driven to the analog side
    typedef struct packed {
        logic [1:0] ref_sel;                     // reference_select
        logic [4:0] chan_sel;                    // channel_select
    } asb_sel_type;

endpackage : asb_pkg

// ### verilog/asb_sar_core.sv
// Purpose: Successive-approximation sequencer, one bit per cycle
// Assumes: Comparator input is synchronous to CLK
// Notes:   Runs total_cyc cycles per start, last RESULT_W of them decide bits
module asb_sar_core #(
    parameter int RES_W = 10                     // Result resolution
) (
    input  wire logic             CLK,           // Converter clock
    input  wire logic             RST,           // Sync reset, high
    input  wire logic             start,         // Begin new approximation
    input  wire logic [5:0]       total_cyc,     // Cycles this conversion
    input  wire logic             comp_high,     // Input above trial level
    output logic [RES_W-1:0]      trial,         // Trial code to the DAC
    output logic                  last_cycle,    // Final cycle of conversion
    output logic                  busy,          // Conversion running
    output logic [RES_W-1:0]      result         // Finished code
);
    logic [5:0]       cnt_reg;                   // Cycles remaining
    logic [RES_W-1:0] trial_reg;                 // Approximation register
    logic [RES_W-1:0] bit_reg;                   // Bit under test
    logic [RES_W-1:0] result_reg;                // Last finished code
    logic [5:0]       cnt_next;                  // Counter next value
    logic             deciding;                  // In a bit-decision cycle

    assign busy       = (cnt_reg != 6'h00);
    assign last_cycle = (cnt_reg == 6'h01);
    // Decisions take the last RES_W cycles; earlier ones are settle time
    assign deciding   = busy && (cnt_reg <= 6'(RES_W));
    assign cnt_next   = start ? total_cyc : (busy ? cnt_reg - 6'h01 : 6'h00);
    assign trial      = trial_reg;
    assign result     = result_reg;

    // Cycle counter
    always_ff @(posedge CLK) begin
        if (RST) cnt_reg <= 6'h00;
        else     cnt_reg <= cnt_next;
    end

    // Bit decisions; an input above reference keeps every bit, giving max
    always_ff @(posedge CLK) begin
        if (RST || start) begin
            trial_reg <= {1'b1, {(RES_W-1){1'b0}}};
            bit_reg   <= {1'b1, {(RES_W-1){1'b0}}};
        end else if (deciding) begin
            trial_reg <= (comp_high ? trial_reg : (trial_reg & ~bit_reg))
                         | (bit_reg >> 1);
            bit_reg   <= bit_reg >> 1;
        end
    end

    // Latch finished code at the last cycle
    always_ff @(posedge CLK) begin
        if (RST) begin
            result_reg <= '0;
        end else if (last_cycle) begin
            result_reg <= comp_high ? trial_reg : (trial_reg & ~bit_reg);
        end
    end
endmodule // asb_sar_core

// ### verilog/asb_top.sv
// Purpose: Selection buffering, start control and sleep-time conversion
// Assumes: APB slave, CLK is the converter clock, inputs synchronous
// Notes:   Analog side sees SEL_ACTIVE, comparator returns COMP_HIGH
// Functional notes
// R01: Selection held in CPU-writable buffer register
// R02: Idle: buffer copied to active every cycle
// R03: Conversion running: active selection frozen
// R04: Copying resumes in final conversion cycle
// R05: Start takes effect at next clock edge
// R06: Software waits one cycle before reselecting
// R07: Auto-trigger: software updates only at safe points
// R08: Free-running restart keeps old selection
// R09: Reference chosen from supply, internal, external pin
// R10: Software discards first result after reference change
// R11: Input above reference gives 0x3FF
// R12: Sleep conversion needs enabled idle single mode; code does not check auto_trigger_enable
// R13: Noise or idle sleep starts conversion
// R14: Complete request raised even after other wake
// R15: Other sleep modes leave converter enabled
// R16: Reference codes 00 pin,01 supply,11 internal
// R17: Start bit reads one while converting
// R18: Conversions last 13, first 25 cycles
// R19: Selection read returns buffered value
module asb_top #(
    parameter int RES_W = asb_pkg::RESULT_W      // Result resolution
) (
    input  wire logic        CLK,                // Converter clock
    input  wire logic        RST,                // Sync reset, high
    input  wire logic        PSEL,               // APB select
    input  wire logic        PENABLE,            // APB access phase
    input  wire logic        PWRITE,             // APB write
    input  wire logic [7:0]  PADDR,              // APB byte address
    input  wire logic [31:0] PWDATA,             // APB write data
    output logic [31:0]      PRDATA,             // APB read data
    output logic             PREADY,             // APB ready
    output logic             PSLVERR,            // APB error
    input  wire logic        CPU_SLEEP,          // CPU executes sleep
    input  wire logic        CPU_HALTED,         // CPU clock halted
    input  wire logic        CPU_WAKE,           // CPU woken up
    input  wire logic        AUTO_TRIGGER,       // External trigger level
    input  wire logic        COMP_HIGH,          // Comparator output
    output asb_pkg::asb_sel_type SEL_ACTIVE,     // Selection to analog
    output logic [RES_W-1:0] DAC_CODE,           // Trial code to DAC
    output logic             REF_EXT_EN,         // External pin reference
    output logic             REF_SUPPLY_EN,      // Analog supply reference
    output logic             REF_INTERNAL_EN,    // Internal reference on
    output logic             CONV_IRQ,           // Complete request level
    output logic             IRQ                 // Event interrupt level
);
    typedef enum logic [1:0] {
        ST_OFF,                                  // Converter disabled
        ST_IDLE,                                 // Enabled, waiting
        ST_CONV                                  // Conversion running
    } asb_state_type;

    // Address decode of one bus access
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    asb_state_type     state_reg;                // Sequencer state
    asb_state_type     state_next;               // Sequencer next state
    logic [7:0]        sel_buf_reg;              // Buffered selection
    asb_pkg::asb_sel_type active_reg;            // Active selection
    logic [7:0]        ctrl_reg;                 // Control bits
    logic              start_pend_reg;           // Start awaits next edge
    logic              first_reg;                // Next conversion is first
    logic              trig_prev_reg;            // Trigger edge detector
    logic              sleep_mode_reg;           // Sleep conversion armed
    logic [2:0]        sleep_code_reg;           // Commanded sleep mode
    localparam int IRQ_W_L = asb_pkg::IRQ_W;
    logic [IRQ_W_L-1:0] irq_stat_reg;            // Sticky events
    logic [IRQ_W_L-1:0] irq_en_reg;              // Event enables

    logic              wr_en;                    // Write access phase
    logic              wr_sel;                   // Selection write
    logic              wr_ctrl;                  // Control write
    logic              wr_ien;                   // Enable write
    logic              wr_iclr;                  // Clear write
    logic              wr_sleep;                 // Sleep code write
    logic              addr_ok;                  // Mapped address
    logic              enabled;                  // converter_enable
    logic              auto_on;                  // auto_trigger_enable
    logic              free_run;                 // Flag is trigger source
    logic              trig_edge;                // Rising trigger
    logic              sleep_start;              // Sleep-time start
    logic              begin_conv;               // Start this cycle
    logic              conv_done;                // Last conversion cycle
    logic              core_busy;                // Core running
    logic              copy_sel;                 // Buffer flows to active
    logic [5:0]        conv_len;                 // Length of this one
    logic [RES_W-1:0]  core_result;              // Core finished code
    logic [IRQ_W_L-1:0] irq_set;                 // Events this cycle
    logic [31:0]       rd_mux;                   // Read data selection
    logic              conv_done_core;           // Core final cycle
    logic              restart;                  // Free-running restart

    // Bus decode
    assign wr_en    = PSEL && PENABLE && PWRITE;
    assign wr_sel   = wr_en && hit(PADDR, asb_pkg::SEL_OFFSET);
    assign wr_ctrl  = wr_en && hit(PADDR, asb_pkg::CTRL_OFFSET);
    assign wr_ien   = wr_en && hit(PADDR, asb_pkg::IRQ_ENABLE_OFFSET);
    assign wr_iclr  = wr_en && hit(PADDR, asb_pkg::IRQ_CLEAR_OFFSET);
    assign wr_sleep = wr_en && hit(PADDR, asb_pkg::SLEEP_OFFSET);
    // Dense map: every aligned word up to the sleep register
    assign addr_ok  = (PADDR[1:0] == 2'h0)
                   && (PADDR <= asb_pkg::SLEEP_OFFSET);
    assign PREADY   = 1'b1;                      // Zero wait states
    assign PSLVERR  = PSEL && PENABLE && !addr_ok;

    // Mode decode
    assign enabled  = ctrl_reg[asb_pkg::CTRL_ENABLE_BIT];
    assign auto_on  = ctrl_reg[asb_pkg::CTRL_AUTO_BIT];
    assign free_run = auto_on && ctrl_reg[asb_pkg::CTRL_FREE_BIT];
    assign trig_edge = auto_on && !free_run && AUTO_TRIGGER && !trig_prev_reg;
    // Sleep start once the CPU clock is halted in idle or noise mode
    assign sleep_start = sleep_mode_reg && CPU_HALTED && enabled
                      && (sleep_code_reg == asb_pkg::SLEEP_IDLE
                       || sleep_code_reg == asb_pkg::SLEEP_NOISE); // R13
    // Edges during a conversion are ignored by the state condition
    assign begin_conv = (state_reg == ST_IDLE)
                     && (start_pend_reg || trig_edge || sleep_start); // R05
    assign conv_done  = (state_reg == ST_CONV) && conv_done_core;
    assign conv_len   = first_reg ? 6'(asb_pkg::CONV_FIRST_CYC)
                                  : 6'(asb_pkg::CONV_NORMAL_CYC); // R18
    // Frozen from the start edge until the final cycle
    assign copy_sel = !core_busy || conv_done_core;  // R02 R03 R04

    // Successive-approximation core
    asb_sar_core #(
        .RES_W      (RES_W)
    ) u_core (
        .CLK        (CLK),
        .RST        (RST),
        .start      (begin_conv || restart),
        .total_cyc  (conv_len),
        .comp_high  (COMP_HIGH),                 // R11
        .trial      (DAC_CODE),
        .last_cycle (conv_done_core),
        .busy       (core_busy),
        .result     (core_result)
    );

    assign restart = conv_done && free_run;      // R08

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF:  if (enabled) state_next = ST_IDLE;
            ST_IDLE: begin
                if (!enabled)       state_next = ST_OFF;
                else if (begin_conv) state_next = ST_CONV;
            end
            ST_CONV: if (conv_done && !restart) state_next = ST_IDLE;
            default: state_next = ST_OFF;
        endcase
    end

    // State register; disabling mid-conversion lets it finish
    always_ff @(posedge CLK) begin
        if (RST) state_reg <= ST_OFF;
        else     state_reg <= state_next;
    end

    // Buffered selection, writable at any time
    always_ff @(posedge CLK) begin
        if (RST)         sel_buf_reg <= asb_pkg::SEL_RESET;
        else if (wr_sel) sel_buf_reg <= PWDATA[7:0];  // R01
    end

    // Active selection; the restart edge samples the copy taken just before
    always_ff @(posedge CLK) begin
        if (RST) begin
            active_reg <= '0;
        end else if (copy_sel) begin
            active_reg.chan_sel <= sel_buf_reg[asb_pkg::CHAN_LSB +:
                                               asb_pkg::CHAN_W];
            active_reg.ref_sel  <= sel_buf_reg[asb_pkg::REF_LSB +:
                                               asb_pkg::REF_W];
        end
    end

    // Reference switch decode from the active selection
    assign REF_EXT_EN      = enabled
                          && active_reg.ref_sel == asb_pkg::REF_EXT_PIN;
    assign REF_SUPPLY_EN   = enabled
                          && active_reg.ref_sel == asb_pkg::REF_SUPPLY;
    assign REF_INTERNAL_EN = enabled
                          && active_reg.ref_sel == asb_pkg::REF_INTERNAL;
    assign SEL_ACTIVE      = active_reg;     // R09 R16

    // Control bits; start bit is hardware cleared on single completion
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_reg <= asb_pkg::CTRL_RESET;
        end else begin
            // Flag is write one to clear; a completion set wins
            if (wr_ctrl) begin
                ctrl_reg <= (PWDATA[7:0] & 8'hA9)
                          | (ctrl_reg & ~PWDATA[7:0] & 8'h10);
            end
            if (conv_done) begin
                ctrl_reg[asb_pkg::CTRL_FLAG_BIT] <= 1'b1;
            end
        end
    end

    // Pending start, first-conversion marker and trigger history
    always_ff @(posedge CLK) begin
        if (RST) begin
            start_pend_reg <= 1'b0;
            first_reg      <= 1'b1;
            trig_prev_reg  <= 1'b0;
        end else begin
            trig_prev_reg <= AUTO_TRIGGER;
            if (begin_conv || !enabled) begin
                start_pend_reg <= 1'b0;
            end else if (wr_ctrl && PWDATA[asb_pkg::CTRL_START_BIT]
                         && PWDATA[asb_pkg::CTRL_ENABLE_BIT]) begin
                start_pend_reg <= 1'b1;
            end
            if (state_reg == ST_OFF) first_reg <= 1'b1;
            else if (begin_conv)     first_reg <= 1'b0;
        end
    end

    // Sleep arming; any other mode leaves the converter as it was
    always_ff @(posedge CLK) begin
        if (RST) begin
            sleep_mode_reg <= 1'b0;
            sleep_code_reg <= asb_pkg::SLEEP_IDLE;
        end else begin
            if (wr_sleep) sleep_code_reg <= PWDATA[2:0];  // R15
            if (sleep_start || CPU_WAKE) begin
                sleep_mode_reg <= 1'b0;          // Disarmed by sleep start or wake
            end else if (CPU_SLEEP) begin
                sleep_mode_reg <= 1'b1;
            end
        end
    end

    // Sticky events; a set in the clearing cycle wins
    assign irq_set[asb_pkg::IRQ_DONE_BIT]  = conv_done;
    assign irq_set[asb_pkg::IRQ_START_BIT] = begin_conv;
    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_stat_reg <= '0;
            irq_en_reg   <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg
                            & ~(wr_iclr ? PWDATA[IRQ_W_L-1:0] : '0))
                            | irq_set;
            if (wr_ien) irq_en_reg <= PWDATA[IRQ_W_L-1:0];
        end
    end
    assign IRQ = |(irq_stat_reg & irq_en_reg);
    // Complete request follows the flag, whoever woke the CPU
    assign CONV_IRQ = ctrl_reg[asb_pkg::CTRL_FLAG_BIT]
                   && ctrl_reg[asb_pkg::CTRL_IE_BIT];  // R14

    // Read data selection
    assign rd_mux =
        hit(PADDR, asb_pkg::SEL_OFFSET)  ? {24'h0, sel_buf_reg} :  // R19
        hit(PADDR, asb_pkg::CTRL_OFFSET) ?
            {24'h0, ctrl_reg | {1'b0, (start_pend_reg || core_busy),
                                6'h00}} :                          // R17
        hit(PADDR, asb_pkg::RESULT_OFFSET) ?
            {{(32-RES_W){1'b0}}, core_result} :
        hit(PADDR, asb_pkg::IRQ_STATUS_OFFSET) ?
            {{(32-IRQ_W_L){1'b0}}, irq_stat_reg} :
        hit(PADDR, asb_pkg::IRQ_ENABLE_OFFSET) ?
            {{(32-IRQ_W_L){1'b0}}, irq_en_reg} :
        hit(PADDR, asb_pkg::SLEEP_OFFSET) ?
            {29'h0, sleep_code_reg} : 32'h0;

    // Registered read data
    always_ff @(posedge CLK) begin
        if (RST)                  PRDATA <= 32'h0;
        else if (PSEL && !PENABLE) PRDATA <= rd_mux;
    end
endmodule // asb_top

// ### testbench/asb_analog_model.sv
// Purpose: Analog inputs and comparator facing the converter
// Assumes: Channel level is its number times 64 LSB
// Notes:   Channels 16 and up sit above any reference: full scale
module asb_analog_model (
    input  wire asb_pkg::asb_sel_type sel,      // Active selection
    input  wire logic [9:0]           dac,      // Trial code
    output logic                      comp_high // Input above trial
);
    logic [10:0] level; // Selected input level
    // Eleven bits so an over-range input never wraps to a low code
    assign level = {sel.chan_sel, 6'h00};
    assign comp_high = level > {1'h0, dac};
endmodule // asb_analog_model

// ### testbench/asb_top_checker.sv
// Purpose: Port checks of selection locking and conversion timing
// Assumes: Complete interrupt enabled for every conversion
// Notes:   Run state rebuilt from control writes; busy is no port
module asb_top_checker (
    input wire logic                 CLK,             // Clock
    input wire logic                 RST,             // Reset
    input wire logic                 PSEL,            // Select
    input wire logic                 PENABLE,         // Access
    input wire logic                 PWRITE,          // Write
    input wire logic [7:0]           PADDR,           // Address
    input wire logic [31:0]          PWDATA,          // Data
    input wire asb_pkg::asb_sel_type SEL_ACTIVE,      // Selection
    input wire logic                 REF_EXT_EN,      // Pin ref
    input wire logic                 REF_SUPPLY_EN,   // Supply ref
    input wire logic                 REF_INTERNAL_EN, // Internal ref
    input wire logic                 CONV_IRQ         // Complete
);
    logic wr, sel_wr, ctl_wr, st_wr;         // Decoded writes
    logic en_q, first_q, busy_q, free_q;     // Shadow run state
    asb_pkg::asb_sel_type buf_q;             // Shadow buffer
    logic [1:0] ref_w;                       // Active reference
    assign ref_w = en_q ? SEL_ACTIVE.ref_sel : 2'h2; // Off: no source
    assign wr = PSEL && PENABLE && PWRITE;
    assign sel_wr = wr && PADDR == asb_pkg::SEL_OFFSET;
    assign ctl_wr = wr && PADDR == asb_pkg::CTRL_OFFSET;
    assign st_wr = ctl_wr && PWDATA[7] && PWDATA[6];
    // Free running never leaves busy at completion
    always_ff @(posedge CLK) begin
        if (RST) {en_q, first_q, busy_q, free_q, buf_q} <= 11'h000;
        else begin
            if (sel_wr) buf_q <= {PWDATA[7:6], PWDATA[4:0]};
            if (ctl_wr) {en_q, free_q} <= {PWDATA[7], PWDATA[5] & PWDATA[0]};
            if (ctl_wr) first_q <= PWDATA[7] & ~PWDATA[6] & (~en_q | first_q);
            if (ctl_wr) busy_q <= st_wr | (busy_q & PWDATA[7]);
            else if ($rose(CONV_IRQ) && !free_q) busy_q <= 1'h0;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_locked; ##2 $stable(SEL_ACTIVE) [*8]; endsequence
    sequence s_quiet; ##1 (!CONV_IRQ) [*8]; endsequence
    a_ref_pin: assert property (REF_EXT_EN == (ref_w == 2'h0))
        else $error("pin reference enable wrong");
    a_ref_supply: assert property (REF_SUPPLY_EN == (ref_w == 2'h1))
        else $error("supply reference enable wrong");
    a_ref_internal: assert property (REF_INTERNAL_EN == (ref_w == 2'h3))
        else $error("internal reference enable wrong");
    a_idle_copy: assert property (sel_wr && en_q && !busy_q
        |-> ##[1:2] SEL_ACTIVE == buf_q) else $error("idle copy missing");
    a_sel_locked: assert property (st_wr |-> s_locked)
        else $error("selection moved in conversion");
    a_copy_resume: assert property ($rose(CONV_IRQ)
        |-> SEL_ACTIVE == buf_q) else $error("no copy in last cycle");
    a_first_len: assert property (st_wr && (!en_q || first_q)
        |-> s_quiet ##[17:19] $rose(CONV_IRQ)) else $error("first length");
    a_normal_len: assert property (st_wr && en_q && !first_q && !busy_q
        |-> s_quiet ##[5:7] $rose(CONV_IRQ)) else $error("normal length");
endmodule // asb_top_checker
bind asb_top asb_top_checker asb_top_checker_inst (.*);

// ### testbench/asb_top_tb.sv
// Purpose: Self-checking bench for selection locking and sleep start
// Assumes: Zero-wait APB slave, analog side from the model
// Notes:   Bench signals carry the port names, instance uses .*
module asb_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR; // Bus
    logic        CPU_SLEEP, CPU_HALTED, CPU_WAKE, AUTO_TRIGGER;    // CPU
    logic        COMP_HIGH, CONV_IRQ, IRQ, err, got;               // Flags
    logic        REF_EXT_EN, REF_SUPPLY_EN, REF_INTERNAL_EN;       // Refs
    logic [7:0]  PADDR;                                            // Addr
    logic [9:0]  DAC_CODE;                                         // Trial
    logic [31:0] PWDATA, PRDATA, rdv;                              // Data
    logic [1:0]  refs [3] = '{2'h0, 2'h1, 2'h3};                   // Codes
    logic [2:0]  ens [3] = '{3'h4, 3'h2, 3'h1};                    // Enables
    asb_pkg::asb_sel_type SEL_ACTIVE;                              // Active
    int          fails, n_compared, cyc;                           // Counts
    asb_top asb_top_inst (.*);
    asb_analog_model asb_analog_model_inst (.sel(SEL_ACTIVE),
        .dac(DAC_CODE), .comp_high(COMP_HIGH));
    // One transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'h2, w, a, d};
        @(posedge CLK);
        PENABLE <= 1'h1;
        @(posedge CLK);
        while (PREADY !== 1'h1) @(posedge CLK);
        {rdv, err} = {PRDATA, PSLVERR};
        {PSEL, PENABLE} <= 2'h0;
        @(negedge CLK);
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Sampled mid-cycle so the flag has settled
    task automatic wait_irq(input int lim);
        got = 1'h0;
        repeat (lim) if (got !== 1'h1) begin
            @(negedge CLK);
            got = CONV_IRQ;
        end
    endtask
    // Sleep entry, optionally woken early by another source
    task automatic nap(input logic [2:0] m, input logic wake);
        apb(1, asb_pkg::SLEEP_OFFSET, {29'h0, m});
        apb(1, asb_pkg::CTRL_OFFSET, 32'h98);
        @(posedge CLK) CPU_SLEEP <= 1'h1;
        @(posedge CLK) {CPU_SLEEP, CPU_HALTED} <= 2'h1;
        repeat (4) @(posedge CLK);
        {CPU_WAKE, CPU_HALTED} <= {wake, ~wake};
        @(posedge CLK) CPU_WAKE <= 1'h0;
        wait_irq(60);
        @(posedge CLK) CPU_HALTED <= 1'h0;
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        CLK = 1'h0;
        forever #50 CLK = ~CLK;
    end
    // About 300 cycles needed; ample margin
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            print_verdict();
        end
    end
    initial begin
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = 43'h0;
        {CPU_SLEEP, CPU_HALTED, CPU_WAKE, AUTO_TRIGGER, RST} = 5'h1;
        repeat (20) @(posedge CLK);
        RST <= 1'h0;
        apb(0, asb_pkg::SEL_OFFSET, 0);
        chk("sel reset", rdv, 32'h0);
        apb(0, 8'h1C, 0);
        chk("unmapped", {err, rdv[30:0]}, 32'h80000000);
        apb(1, asb_pkg::CTRL_OFFSET, 32'h80);
        foreach (refs[i]) begin
            apb(1, asb_pkg::SEL_OFFSET, {24'h0, refs[i], 6'h05});
            @(negedge CLK);
            chk("active", SEL_ACTIVE, {refs[i], 5'h05});
            chk("refs", {REF_EXT_EN, REF_SUPPLY_EN, REF_INTERNAL_EN}, ens[i]);
            apb(0, asb_pkg::SEL_OFFSET, 0);
            chk("sel read", rdv, {24'h0, refs[i], 6'h05});
        end
        $display("test selection done");
        apb(1, asb_pkg::SEL_OFFSET, 32'h10);
        apb(1, asb_pkg::CTRL_OFFSET, 32'hC8);
        apb(1, asb_pkg::SEL_OFFSET, 32'h02);
        chk("locked", SEL_ACTIVE, 7'h10);
        apb(0, asb_pkg::CTRL_OFFSET, 0);
        chk("start busy", rdv[6], 1'h1);
        apb(0, asb_pkg::SEL_OFFSET, 0);
        chk("buffer", rdv, 32'h02);
        wait_irq(40);
        chk("first done", got, 1'h1);
        apb(0, asb_pkg::CTRL_OFFSET, 0);
        chk("start clear", rdv[6], 1'h0);
        chk("resumed", SEL_ACTIVE, 7'h02);
        apb(0, asb_pkg::RESULT_OFFSET, 0);
        chk("full scale", rdv, {22'h0, asb_pkg::RESULT_MAX});
        apb(1, asb_pkg::CTRL_OFFSET, 32'hD8);
        wait_irq(30);
        apb(0, asb_pkg::IRQ_STATUS_OFFSET, 0);
        chk("events", {rdv[30:0], IRQ}, 32'h6);
        apb(1, asb_pkg::IRQ_ENABLE_OFFSET, 32'h1);
        chk("irq on", IRQ, 1'h1);
        apb(1, asb_pkg::IRQ_CLEAR_OFFSET, 32'h1);
        chk("irq off", {IRQ, CONV_IRQ}, 2'h1);
        $display("test single conversion done");
        apb(1, asb_pkg::CTRL_OFFSET, 32'hF9);
        wait_irq(30);
        apb(1, asb_pkg::SEL_OFFSET, 32'h05);
        chk("restart old", SEL_ACTIVE, 7'h02);
        apb(1, asb_pkg::CTRL_OFFSET, 32'hB9);
        wait_irq(30);
        chk("later new", SEL_ACTIVE, 7'h05);
        apb(1, asb_pkg::CTRL_OFFSET, 32'h00);
        $display("test free running done");
        nap(asb_pkg::SLEEP_NOISE, 1'h0);
        chk("noise sleep", got, 1'h1);
        nap(asb_pkg::SLEEP_IDLE, 1'h1);
        chk("early wake", got, 1'h1);
        nap(3'h2, 1'h0);
        chk("deep sleep", got, 1'h0);
        apb(0, asb_pkg::CTRL_OFFSET, 0);
        chk("still on", rdv[7], 1'h1);
        $display("test sleep done");
        print_verdict();
    end
endmodule // asb_top_tb
